/* File: amu_blk_model.sv */
`timescale 1ns/1ns
module amu_blk_model (
    // Scan clock
    input wire logic clk,
    // Actual values of the neighbouring blocks
    output logic [amu_pkg::NBLK*32-1:0] actualValue
);
    import amu_pkg::*;
    // ------------------------------------------------------------
    // Block values
    // ------------------------------------------------------------
    logic [31:0] val [NBLK];

    // Untouched blocks show a non-zero pattern, never a friendly zero
    initial begin
        for (int n = 0; n < NBLK; n++) begin
            val[n] = 32'h5a5a_0000 | 32'(n);
        end
    end

    // Whole words change at a clock edge, as another block would
    task automatic put(input int n, input logic [31:0] v);
        @(posedge clk);
        val[n] <= v;
    endtask

    // Flatten, block n at word n
    always_comb begin
        for (int n = 0; n < NBLK; n++) begin
            actualValue[n*32 +: 32] = val[n];
        end
    end
endmodule

/* File: amu_math_unit.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// Functional notes
// - Rising enable edge activates; compute only while enabled
// - Four operands, three operators between neighbours
// - Operator is add, subtract, multiply or divide
// - High priority first, then medium, then low
// - Final result rounded to nearest integer
// - Zero division or overflow outputs 32767
// - Negative overflow outputs -32768
// - Disabled: mode 0 clears, mode 1 holds
// - Block operands clamped to 16-bit range
// - Operand is constant or block actual value
// - Separate zero-division and overflow flags
// - Decimal places affect display only
// - Both flags rewritten after every execution
module amu_math_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // AXI4-Lite write address and data
    input wire logic [amu_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [amu_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [amu_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [amu_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Function block side
    input wire logic enable,
    input wire logic [amu_pkg::NBLK*32-1:0] actualValue,
    output logic [amu_pkg::VAL_W-1:0] resultOutput,
    output logic zeroDivFlag,
    output logic overflowFlag,
    output logic irq
);
    import amu_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} amu_state_t;

    logic [31:0] ctrlReg;
    logic [31:0] opsReg;
    logic [31:0] opndReg [0:3];
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    amu_state_t state;
    logic enablePrev;
    logic active;
    logic [1:0] step;
    logic [3:0] alive;
    logic signed [WIDE_W-1:0] vals [0:3];
    logic errZd;
    logic errPos;
    logic errNeg;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    wire wrFire = awvalid && wvalid && !bvalid;
    wire wrOpnd = (awaddr >= REG_OPND0) && (awaddr <= REG_OPND3) && (awaddr[1:0] == 2'h0);
    wire [1:0] wrIdx = 2'(awaddr[5:2] - 4'h2);
    wire wrCtrl = wrFire && (awaddr == REG_CTRL);
    wire wrOps = wrFire && (awaddr == REG_OPS);
    wire wrIrqEn = wrFire && (awaddr == REG_IRQ_EN);
    wire wrIrqClr = wrFire && (awaddr == REG_IRQ_CLR);
    wire wrMapped = (awaddr == REG_CTRL) || (awaddr == REG_OPS) || wrOpnd
        || (awaddr == REG_IRQ_EN) || (awaddr == REG_IRQ_CLR);
    wire [31:0] strbMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [IRQ_W-1:0] clrMask = wrIrqClr ? (wdata[IRQ_W-1:0] & strbMask[IRQ_W-1:0]) : '0;

    // Address and data are taken together, never one without the other
    assign awready = wrFire;
    assign wready = wrFire;
    assign arready = !rvalid;

    // Write response handshake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Configuration registers with byte lanes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg <= CTRL_RST;
            opsReg <= OPS_RST;
            irqEn <= '0;
            for (int i = 0; i < 4; i++) begin
                opndReg[i] <= OPND_RST;
            end
        end else begin
            if (wrCtrl) ctrlReg <= (ctrlReg & ~strbMask) | (wdata & strbMask);
            if (wrOps) opsReg <= (opsReg & ~strbMask) | (wdata & strbMask);
            if (wrIrqEn) irqEn <= (irqEn & ~strbMask[IRQ_W-1:0]) | (wdata[IRQ_W-1:0] & strbMask[IRQ_W-1:0]);
            if (wrFire && wrOpnd) begin
                opndReg[wrIdx] <= (opndReg[wrIdx] & ~strbMask) | (wdata & strbMask);
            end
        end
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    wire rdFire = arvalid && arready;
    wire rdOpnd = (araddr >= REG_OPND0) && (araddr <= REG_OPND3) && (araddr[1:0] == 2'h0);
    wire [1:0] rdIdx = 2'(araddr[5:2] - 4'h2);
    wire [31:0] statusWord = {28'h0000000, state != ST_IDLE, active, overflowFlag, zeroDivFlag};
    wire rdMapped = (araddr == REG_CTRL) || (araddr == REG_OPS) || rdOpnd
        || (araddr == REG_RESULT) || (araddr == REG_STATUS) || (araddr == REG_IRQ_STAT)
        || (araddr == REG_IRQ_CLR) || (araddr == REG_IRQ_EN);
    wire [31:0] rdMux =
        (araddr == REG_CTRL) ? ctrlReg :
        (araddr == REG_OPS) ? opsReg :
        rdOpnd ? opndReg[rdIdx] :
        (araddr == REG_RESULT) ? {16'h0000, resultOutput} :
        (araddr == REG_STATUS) ? statusWord :
        (araddr == REG_IRQ_STAT) ? {29'h00000000, irqStat} :
        (araddr == REG_IRQ_EN) ? {29'h00000000, irqEn} : 32'h0000_0000;

    // Read data held until the master takes it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Operand sources
    // ------------------------------------------------------------
    logic signed [VAL_W-1:0] opndVal [0:3];
    for (genvar g = 0; g < 4; g++) begin : gOpnd
        wire [BLK_W-1:0] blkSel = opndReg[g][OPND_BLK_LSB +: BLK_W];
        wire signed [31:0] blkVal = actualValue[blkSel*32 +: 32];
        // Out of range actual values pinned to the nearest limit
        wire signed [VAL_W-1:0] clamped = (blkVal > IN_MAX) ? OUT_MAX :
            (blkVal < IN_MIN) ? OUT_MIN : blkVal[VAL_W-1:0];
        assign opndVal[g] = opndReg[g][OPND_SRC_BIT] ? clamped :
            opndReg[g][OPND_CONST_LSB +: VAL_W];
        a_p_clamp_hi: assert property (@(posedge clk) disable iff (!arst_n)
            blkVal > IN_MAX |-> clamped == OUT_MAX) else $error("clamp high wrong");
    end

    // ------------------------------------------------------------
    // Priority ordered evaluation
    // ------------------------------------------------------------
    // The step number doubles as the priority code being served
    wire [1:0] opIdx = (opsReg[OPS_PR_LSB +: 2] == step) ? 2'h0 :
        (opsReg[OPS_PR_LSB + 2 +: 2] == step) ? 2'h1 : 2'h2;
    wire [1:0] rightIdx = opIdx + 2'h1;
    // Left term is the surviving head of the segment holding operand opIdx
    wire [1:0] leftIdx = alive[opIdx] ? opIdx :
        (opIdx != 2'h0 && alive[opIdx - 2'h1]) ? opIdx - 2'h1 : 2'h0;
    wire amu_op_t curOp = amu_op_t'(opsReg[OPS_OP_LSB + 2*opIdx +: 2]);
    logic signed [WIDE_W-1:0] stepY;
    logic stepZd;
    logic stepPos;
    logic stepNeg;

    amu_op_unit #(.W(WIDE_W), .F(FRAC_W)) uOp (
        .a(vals[leftIdx]),
        .b(vals[rightIdx]),
        .op(curOp),
        .y(stepY),
        .divZero(stepZd),
        .ovfPos(stepPos),
        .ovfNeg(stepNeg)
    );

    // Activation on a true low to high edge only
    wire enRise = enable && !enablePrev;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enablePrev <= 1'b1;
            active <= 1'b0;
        end else begin
            enablePrev <= enable;
            active <= enable && (active || enRise);
        end
    end

    // Sequencer: load, three steps, finish; restarts each pass while enabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            step <= 2'h0;
        end else if (!enable) begin
            // An aborted pass must not leave the next one mid-sequence
            state <= ST_IDLE;
            step <= PRIO_HIGH;
        end else begin
            unique case (state)
                ST_IDLE: if (active) state <= ST_RUN;
                ST_RUN: begin
                    step <= step + 2'h1;
                    if (step == PRIO_LOW) state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    step <= PRIO_HIGH;
                end
            endcase
        end
    end

    // Working terms; an executed operation folds its right term away
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alive <= 4'hf;
            errZd <= 1'b0;
            errPos <= 1'b0;
            errNeg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                vals[i] <= '0;
            end
        end else if (state == ST_IDLE) begin
            alive <= 4'hf;
            errZd <= 1'b0;
            errPos <= 1'b0;
            errNeg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                vals[i] <= WIDE_W'(opndVal[i]) <<< FRAC_W;
            end
        end else if (state == ST_RUN) begin
            vals[leftIdx] <= stepY;
            alive[rightIdx] <= 1'b0;
            errZd <= errZd || stepZd;
            errPos <= errPos || stepPos;
            errNeg <= errNeg || stepNeg;
        end
    end

    // ------------------------------------------------------------
    // Rounding, saturation and output
    // ------------------------------------------------------------
    // Half away from zero; decimals setting never enters this path
    wire valNeg = vals[0][WIDE_W-1];
    wire signed [WIDE_W-1:0] mag = (valNeg ? -vals[0] : vals[0]) + ROUND_HALF;
    wire signed [WIDE_W-1:0] magInt = mag >>> FRAC_W;
    wire signed [WIDE_W-1:0] roundedInt = valNeg ? -magInt : magInt;
    wire finPos = errPos || (!errNeg && roundedInt > RES_MAX);
    wire finNeg = !finPos && (errNeg || roundedInt < RES_MIN);
    wire [VAL_W-1:0] finalVal = (errZd || finPos) ? OUT_MAX :
        finNeg ? OUT_MIN : roundedInt[VAL_W-1:0];
    wire holdMode = ctrlReg[CTRL_HOLD_BIT];
    wire [1:0] decimals = ctrlReg[CTRL_DEC_LSB +: 2];
    // A pass cut by enable low writes neither result, flags nor events
    wire finish = (state == ST_DONE) && enable;

    // Output update; cleared while disabled unless hold is chosen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resultOutput <= '0;
            zeroDivFlag <= 1'b0;
            overflowFlag <= 1'b0;
        end else if (!enable && !holdMode) begin
            resultOutput <= '0;
        end else if (finish) begin
            resultOutput <= finalVal;
            zeroDivFlag <= errZd;
            overflowFlag <= finPos || finNeg;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [IRQ_W-1:0] irqEvents = finish ? {finPos || finNeg, errZd, 1'b1} : '0;
    // Events OR in after the clear so a same-cycle event survives
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat <= '0;
        end else begin
            irqStat <= (irqStat & ~clrMask) | irqEvents;
        end
    end
    assign irq = |(irqStat & irqEn);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_start;
        @(posedge clk) disable iff (!arst_n)
        (state == ST_IDLE && !active && !enRise) |=> state == ST_IDLE;
    endproperty
    a_start: assert property (p_start) else $error("ran without enable edge");

    property p_order;
        @(posedge clk) disable iff (!arst_n)
        (state == ST_IDLE && active && enable) |=> (state == ST_RUN && step == PRIO_HIGH)
            ##1 (step == PRIO_MED || !enable) ;
    endproperty
    a_order: assert property (p_order) else $error("priority order broken");

    property p_fold;
        @(posedge clk) disable iff (!arst_n)
        (state == ST_RUN && enable) |=> !alive[$past(rightIdx)];
    endproperty
    a_fold: assert property (p_fold) else $error("right term not folded");

    property p_zdiv;
        @(posedge clk) disable iff (!arst_n)
        (finish && errZd && (enable || holdMode)) |=> resultOutput == OUT_MAX && zeroDivFlag;
    endproperty
    a_zdiv: assert property (p_zdiv) else $error("zero division output wrong");

    property p_under;
        @(posedge clk) disable iff (!arst_n)
        (finish && finNeg && !errZd && (enable || holdMode)) |=>
            resultOutput == OUT_MIN && overflowFlag;
    endproperty
    a_under: assert property (p_under) else $error("underflow output wrong");

    property p_clear;
        @(posedge clk) disable iff (!arst_n)
        (!enable && !holdMode) [*2] |-> resultOutput == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("output not cleared");

    property p_hold;
        @(posedge clk) disable iff (!arst_n)
        (!enable && holdMode && state == ST_IDLE) |=> $stable(resultOutput);
    endproperty
    a_hold: assert property (p_hold) else $error("held output moved");

    property p_flags;
        @(posedge clk) disable iff (!arst_n)
        (finish && !errZd && !finPos && !finNeg && (enable || holdMode)) |=>
            !zeroDivFlag && !overflowFlag;
    endproperty
    a_flags: assert property (p_flags) else $error("stale error flag");

    property p_decimals;
        @(posedge clk) disable iff (!arst_n)
        $changed(decimals) && $stable(holdMode) && !finish && enable |=> $stable(resultOutput);
    endproperty
    a_decimals: assert property (p_decimals) else $error("decimals changed result");
endmodule

/* File: amu_math_unit_tb_top.sv */
`timescale 1ns/1ns
module amu_math_unit_tb_top;
    import amu_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, arst_n, enable;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, zeroDivFlag, overflowFlag, irq;
    logic [1:0] bresp, rresp;
    logic [NBLK*32-1:0] actualValue;
    logic [15:0] resultOutput;
    int errors = 0;
    int nTests = 0;

    amu_math_unit uut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .enable(enable), .actualValue(actualValue),
        .resultOutput(resultOutput), .zeroDivFlag(zeroDivFlag),
        .overflowFlag(overflowFlag), .irq(irq));
    amu_blk_model blk (.clk(clk), .actualValue(actualValue));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        nTests++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Ready is sampled mid-cycle so the taking edge is never raced
    task automatic axw(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(negedge clk); while (bvalid !== 1'b1);
        chk("bresp", er, bresp);
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [5:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        v = rdata;
        chk("rresp", er, rresp);
        @(posedge clk);
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] opw(input logic [1:0] o1, o2, o3, p1, p2, p3);
        return {18'h0, p3, p2, p1, 2'h0, o3, o2, o1};
    endfunction
    // Configure with enable low, then one rising edge; a pass takes five cycles
    task automatic run(input logic [31:0] ops, v0, v1, v2, v3, input logic [15:0] r,
                       input logic zd, input logic of);
        logic [31:0] v [4];
        v = '{v0, v1, v2, v3};
        @(posedge clk);
        enable <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            axw(REG_OPND0 + 6'(4*k), v[k], RESP_OKAY);
        end
        axw(REG_OPS, ops, RESP_OKAY);
        @(posedge clk);
        enable <= 1'b1;
        repeat (8) @(negedge clk);
        chk("resultOutput", {16'h0, r}, {16'h0, resultOutput});
        chk("zeroDivFlag", 32'(zd), 32'(zeroDivFlag));
        chk("overflowFlag", 32'(of), 32'(overflowFlag));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        axr(REG_OPS, RESP_OKAY, d);
        chk("OPS", OPS_RST, d);
        axr(REG_CTRL, RESP_OKAY, d);
        chk("CTRL", CTRL_RST, d);
        chk("resultOutput", 32'h0, {16'h0, resultOutput});
    endtask
    task automatic t_examples();
        run(opw(OP_ADD, OP_DIV, OP_SUB, 1, 0, 2), 12, 6, 3, 1, 16'd13, 0, 0);
        run(opw(OP_ADD, OP_MUL, OP_ADD, 2, 1, 0), 2, 3, 1, 4, 16'd17, 0, 0);
        run(opw(OP_SUB, OP_DIV, OP_ADD, 0, 2, 1), 100, 25, 2, 1, 16'd25, 0, 0);
    endtask
    task automatic t_round();
        run(opw(OP_DIV, OP_ADD, OP_ADD, 0, 1, 2), 7, 2, 0, 0, 16'd4, 0, 0);
        run(opw(OP_DIV, OP_ADD, OP_ADD, 0, 1, 2), 32'hfff9, 2, 0, 0, 16'hfffc, 0, 0);
    endtask
    task automatic t_errors();
        run(opw(OP_DIV, OP_ADD, OP_ADD, 0, 1, 2), 5, 0, 0, 0, OUT_MAX, 1, 0);
        run(opw(OP_MUL, OP_ADD, OP_ADD, 0, 1, 2), 300, 300, 0, 0, OUT_MAX, 0, 1);
        run(opw(OP_MUL, OP_ADD, OP_ADD, 0, 1, 2), 32'hfed4, 300, 0, 0, OUT_MIN, 0, 1);
        run(opw(OP_ADD, OP_ADD, OP_ADD, 0, 1, 2), 1, 1, 0, 0, 16'd2, 0, 0);
    endtask
    task automatic t_blocks();
        blk.put(3, 32'h0001_86a0);
        blk.put(5, 32'hffff_fb2e);
        run(opw(OP_ADD, OP_ADD, OP_ADD, 0, 1, 2), 32'h31_0000, 32'h51_0000, 0, 0,
            16'h7b2d, 0, 0);
        blk.put(3, 32'hfffe_7960);
        run(opw(OP_MUL, OP_ADD, OP_ADD, 0, 1, 2), 32'h31_0000, 1, 0, 0, OUT_MIN, 0, 0);
    endtask
    task automatic t_modes();
        @(posedge clk);
        enable <= 1'b0;
        repeat (3) @(negedge clk);
        chk("resultOutput", 32'h0, {16'h0, resultOutput});
        axw(REG_CTRL, 32'h7, RESP_OKAY);
        run(opw(OP_ADD, OP_DIV, OP_SUB, 1, 0, 2), 12, 6, 3, 1, 16'd13, 0, 0);
        @(posedge clk);
        enable <= 1'b0;
        axw(REG_OPND0, 32'h40, RESP_OKAY);
        repeat (10) @(negedge clk);
        chk("resultOutput", 32'd13, {16'h0, resultOutput});
    endtask
    task automatic t_irq();
        axw(REG_IRQ_CLR, 32'h7, RESP_OKAY);
        axw(REG_IRQ_EN, 32'h1, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        run(opw(OP_ADD, OP_ADD, OP_ADD, 0, 1, 2), 1, 1, 0, 0, 16'd2, 0, 0);
        @(posedge clk);
        enable <= 1'b0;
        axr(REG_IRQ_STAT, RESP_OKAY, d);
        chk("IRQ_STAT", 32'h1, d);
        chk("irq", 32'h1, 32'(irq));
        axw(REG_IRQ_EN, 32'h0, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        axw(REG_IRQ_EN, 32'h1, RESP_OKAY);
        axw(REG_IRQ_CLR, 32'h1, RESP_OKAY);
        @(negedge clk);
        chk("irq", 32'h0, 32'(irq));
    endtask
    task automatic t_unmapped();
        axw(6'h3c, 32'hffff_ffff, RESP_SLVERR);
        axr(6'h3c, RESP_SLVERR, d);
        chk("unmapped", 32'h0, d);
        axr(REG_IRQ_CLR, RESP_OKAY, d);
        chk("IRQ_CLR", 32'h0, d);
    endtask
    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A few hundred cycles are needed; the limit leaves a wide margin
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        arst_n = 1'b0; enable = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_examples();
        t_round();
        t_errors();
        t_blocks();
        t_modes();
        t_irq();
        t_unmapped();
        wrap_up();
    end
endmodule

/* File: amu_op_unit.sv */
`timescale 1ns/1ns
module amu_op_unit #(
    parameter int W = 64,
    parameter int F = 8
) (
    // Operands in fixed point
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    input wire amu_pkg::amu_op_t op,
    // Result and error indications
    output logic signed [W-1:0] y,
    output logic divZero,
    output logic ovfPos,
    output logic ovfNeg
);
    import amu_pkg::*;

    // ------------------------------------------------------------
    // Double width arithmetic
    // ------------------------------------------------------------
    logic signed [2*W-1:0] aExt;
    logic signed [2*W-1:0] bExt;
    logic signed [2*W-1:0] bSafe;
    logic signed [2*W-1:0] raw;
    logic fits;

    // Divisor forced to one on zero so the divider never sees it
    assign aExt = {{W{a[W-1]}}, a};
    assign bExt = {{W{b[W-1]}}, b};
    assign divZero = (op == OP_DIV) && (b == '0);
    assign bSafe = divZero ? (2*W)'(1) : bExt;

    // Operator select, product and quotient rescaled to keep F fraction bits
    always_comb begin
        unique case (op)
            OP_ADD: raw = aExt + bExt;
            OP_SUB: raw = aExt - bExt;
            OP_MUL: raw = (aExt * bExt) >>> F;
            OP_DIV: raw = (aExt <<< F) / bSafe;
        endcase
    end

    // Intermediate saturation keeps later steps free of wrap-around
    assign fits = (raw[2*W-1:W-2] == '0) || (raw[2*W-1:W-2] == '1);
    assign ovfPos = !divZero && !fits && !raw[2*W-1];
    assign ovfNeg = !divZero && !fits && raw[2*W-1];
    assign y = fits ? raw[W-1:0] :
        (raw[2*W-1] ? {2'b11, {(W-2){1'b0}}} : {2'b00, {(W-2){1'b1}}});
endmodule

/* File: amu_pkg.sv */
package amu_pkg;
    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_OPS = 6'h04;
    localparam logic [5:0] REG_OPND0 = 6'h08;
    localparam logic [5:0] REG_OPND3 = 6'h14;
    localparam logic [5:0] REG_RESULT = 6'h18;
    localparam logic [5:0] REG_STATUS = 6'h1c;
    localparam logic [5:0] REG_IRQ_STAT = 6'h20;
    localparam logic [5:0] REG_IRQ_CLR = 6'h24;
    localparam logic [5:0] REG_IRQ_EN = 6'h28;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_DEC_LSB = 1;
    localparam int OPS_OP_LSB = 0;
    localparam int OPS_PR_LSB = 8;
    localparam int OPND_CONST_LSB = 0;
    localparam int OPND_SRC_BIT = 16;
    localparam int OPND_BLK_LSB = 20;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] OPS_RST = 32'h0000_2400;
    localparam logic [31:0] OPND_RST = 32'h0000_0000;
    localparam int STAT_ZD_BIT = 0;
    localparam int STAT_OF_BIT = 1;
    localparam int STAT_ACT_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ZD_BIT = 1;
    localparam int IRQ_OF_BIT = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Operators, priorities and arithmetic
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} amu_op_t;
    localparam logic [1:0] PRIO_HIGH = 2'h0;
    localparam logic [1:0] PRIO_MED = 2'h1;
    localparam logic [1:0] PRIO_LOW = 2'h2;
    localparam int NBLK = 16;
    localparam int BLK_W = 4;
    localparam int VAL_W = 16;
    localparam int WIDE_W = 64;
    localparam int FRAC_W = 8;
    localparam logic signed [63:0] ROUND_HALF = 64'sh0000_0000_0000_0080;
    localparam logic signed [63:0] RES_MAX = 64'sh0000_0000_0000_7fff;
    localparam logic signed [63:0] RES_MIN = -64'sh0000_0000_0000_8000;
    localparam logic signed [31:0] IN_MAX = 32'sh0000_7fff;
    localparam logic signed [31:0] IN_MIN = -32'sh0000_8000;
    localparam logic [15:0] OUT_MAX = 16'h7fff;
    localparam logic [15:0] OUT_MIN = 16'h8000;
endpackage
